// ===== pfrc_pkg.sv
// Package with register map, field layout and timing constants of the PWM config block
package pfrc_pkg;
	localparam logic [7:0] ADDR_PWM_SWITCHING_FREQUENCY = 8'h40;
	localparam logic [7:0] ADDR_OUT_A_RISE_TIME_UPPER = 8'h41;
	localparam logic [7:0] ADDR_OUT_A_RISE_TIME_LOWER = 8'h42;
	localparam logic [7:0] RST_PWM_SWITCHING_FREQUENCY = 8'h00;
	localparam logic [7:0] RST_OUT_A_RISE_TIME_UPPER = 8'h00;
	localparam logic [7:0] RST_OUT_A_RISE_TIME_LOWER = 8'h00;
	localparam int FREQ_CODE_MSB = 5;
	localparam int LOW_NIBBLE_MSB = 7;
	localparam int LOW_NIBBLE_LSB = 4;
	localparam int MOD_ENABLE_BIT = 3;
	localparam int MOD_SIGN_BIT = 2;
	localparam logic [5:0] CODE_LAST_TABLE = 6'h36;
	localparam logic [5:0] CODE_RESONANT = 6'h3F;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int EDGE_STEP_PS = 5000;
	// Clock ticks per edge-time step, never below one
	localparam int EDGE_STEP_CYCLES = (EDGE_STEP_PS / CLK_PERIOD_PS) < 1 ? 1 :
		EDGE_STEP_PS / CLK_PERIOD_PS;
	localparam logic [12:0] PERIOD_OCT0_BASE = 13'h1000;
	localparam logic [12:0] PERIOD_OCT1_BASE = 13'h0800;
	localparam logic [12:0] PERIOD_OCT2_BASE = 13'h0400;
	localparam logic [12:0] PERIOD_OCT3_BASE = 13'h0200;
	localparam logic [12:0] PERIOD_OCT0_STEP = 13'h0080;
	localparam logic [12:0] PERIOD_OCT1_STEP = 13'h0040;
	localparam logic [12:0] PERIOD_OCT23_STEP = 13'h0020;
	localparam logic [12:0] PERIOD_RST = 13'h1000;
	localparam logic [11:0] EDGE_MAX = 12'hFFF;
endpackage

// ===== pfrc_core.sv
// PWM switching-frequency and output A rising-edge configuration block
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pfrc_core (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Modulation from control loop
	input wire logic [11:0] mod_amount,
	// Timing outputs
	output logic [12:0] period_ticks,
	output logic resonant_mode,
	output logic [11:0] out_a_rise_edge_time,
	output logic period_start,
	output logic primary_output_a
);

	////////////////////////////////////////////////////////////////////////////
	// Period in 5 ns ticks per code; each quarter of the table is one octave
	function automatic logic [12:0] pfrc_period(input logic [5:0] code);
		logic [12:0] step_idx;
		step_idx = {9'h000, code[3:0]};
		if (code > pfrc_pkg::CODE_LAST_TABLE) begin
			// Undefined codes clamp to the fastest tabulated rate
			pfrc_period = pfrc_period_max();
		end else begin
			unique case (code[5:4])
				2'b00: pfrc_period = pfrc_pkg::PERIOD_OCT0_BASE -
					13'(step_idx * pfrc_pkg::PERIOD_OCT0_STEP);
				2'b01: pfrc_period = pfrc_pkg::PERIOD_OCT1_BASE -
					13'(step_idx * pfrc_pkg::PERIOD_OCT1_STEP);
				2'b10: pfrc_period = pfrc_pkg::PERIOD_OCT2_BASE -
					13'(step_idx * pfrc_pkg::PERIOD_OCT23_STEP);
				2'b11: pfrc_period = pfrc_pkg::PERIOD_OCT3_BASE -
					13'(step_idx * pfrc_pkg::PERIOD_OCT23_STEP);
			endcase
		end
	endfunction

	// Fastest tabulated rate, the last defined code
	function automatic logic [12:0] pfrc_period_max();
		pfrc_period_max = pfrc_pkg::PERIOD_OCT3_BASE -
			13'({9'h000, pfrc_pkg::CODE_LAST_TABLE[3:0]} * pfrc_pkg::PERIOD_OCT23_STEP);
	endfunction

	// Later edge: add modulation, pin at the last tick instead of wrapping
	function automatic logic [11:0] pfrc_edge_later(input logic [11:0] edge_in,
		input logic [11:0] amount);
		logic [12:0] sum;
		sum = {1'b0, edge_in} + {1'b0, amount};
		pfrc_edge_later = sum[12] ? pfrc_pkg::EDGE_MAX : sum[11:0];
	endfunction

	// Earlier edge: subtract modulation, floor at the period start
	function automatic logic [11:0] pfrc_edge_earlier(input logic [11:0] edge_in,
		input logic [11:0] amount);
		logic [12:0] diff;
		diff = {1'b0, edge_in} - {1'b0, amount};
		pfrc_edge_earlier = diff[12] ? 12'h000 : diff[11:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] pwm_switching_frequency;
	logic [7:0] out_a_rise_time_upper;
	logic [7:0] out_a_rise_time_lower;
	logic [7:0] next_pwm_switching_frequency;
	logic [7:0] next_out_a_rise_time_upper;
	logic [7:0] next_out_a_rise_time_lower;
	logic [7:0] next_reg_rdata;

	always_comb begin
		next_pwm_switching_frequency = pwm_switching_frequency;
		next_out_a_rise_time_upper = out_a_rise_time_upper;
		next_out_a_rise_time_lower = out_a_rise_time_lower;
		// Reserved bits are stored and read back but steer nothing
		if (reg_wr) begin
			unique case (reg_addr)
				pfrc_pkg::ADDR_PWM_SWITCHING_FREQUENCY: next_pwm_switching_frequency = reg_wdata;
				pfrc_pkg::ADDR_OUT_A_RISE_TIME_UPPER: next_out_a_rise_time_upper = reg_wdata;
				pfrc_pkg::ADDR_OUT_A_RISE_TIME_LOWER: next_out_a_rise_time_lower = reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pwm_switching_frequency <= pfrc_pkg::RST_PWM_SWITCHING_FREQUENCY;
			out_a_rise_time_upper <= pfrc_pkg::RST_OUT_A_RISE_TIME_UPPER;
			out_a_rise_time_lower <= pfrc_pkg::RST_OUT_A_RISE_TIME_LOWER;
		end else begin
			pwm_switching_frequency <= next_pwm_switching_frequency;
			out_a_rise_time_upper <= next_out_a_rise_time_upper;
			out_a_rise_time_lower <= next_out_a_rise_time_lower;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, registered so the port answers one cycle after the address;
	// unmapped addresses read as zero rather than aliasing a mapped register
	always_comb begin
		unique case (reg_addr)
			pfrc_pkg::ADDR_PWM_SWITCHING_FREQUENCY: next_reg_rdata = pwm_switching_frequency;
			pfrc_pkg::ADDR_OUT_A_RISE_TIME_UPPER: next_reg_rdata = out_a_rise_time_upper;
			pfrc_pkg::ADDR_OUT_A_RISE_TIME_LOWER: next_reg_rdata = out_a_rise_time_lower;
			default: next_reg_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge time and modulation
	logic [5:0] freq_code;
	logic [11:0] base_edge;
	logic [11:0] mod_edge;
	logic [12:0] code_period;
	logic code_resonant;

	always_comb begin
		freq_code = pwm_switching_frequency[pfrc_pkg::FREQ_CODE_MSB:0];
		code_period = pfrc_period(freq_code);
		code_resonant = (freq_code == pfrc_pkg::CODE_RESONANT);
		// Both bytes always used together, never the upper byte alone
		base_edge = {out_a_rise_time_upper,
			out_a_rise_time_lower[pfrc_pkg::LOW_NIBBLE_MSB:pfrc_pkg::LOW_NIBBLE_LSB]};
		// Modulation only moves the edge; the period is never stretched
		mod_edge = base_edge;
		if (out_a_rise_time_lower[pfrc_pkg::MOD_ENABLE_BIT]) begin
			if (out_a_rise_time_lower[pfrc_pkg::MOD_SIGN_BIT]) begin
				mod_edge = pfrc_edge_later(base_edge, mod_amount);
			end else begin
				mod_edge = pfrc_edge_earlier(base_edge, mod_amount);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Period counter in 5 ns ticks; settings taken only at period start so
	// a register write never yields a runt pulse
	logic [12:0] tick_cnt;
	logic [12:0] next_tick_cnt;
	logic [12:0] next_period_ticks;
	logic next_resonant_mode;
	logic [11:0] next_out_a_rise_edge_time;
	logic next_period_start;
	logic next_primary_output_a;
	logic wrap;

	always_comb begin
		// Compare with >= so a shortened period never overruns the counter
		wrap = (tick_cnt >= period_ticks - 13'h0001);
		next_period_ticks = period_ticks;
		next_resonant_mode = resonant_mode;
		next_out_a_rise_edge_time = out_a_rise_edge_time;
		next_tick_cnt = tick_cnt + 13'(pfrc_pkg::EDGE_STEP_CYCLES);
		next_period_start = 1'b0;
		if (wrap) begin
			next_tick_cnt = 13'h0000;
			next_period_ticks = code_period;
			next_resonant_mode = code_resonant;
			next_out_a_rise_edge_time = mod_edge;
			next_period_start = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tick_cnt <= 13'h0000;
			period_ticks <= pfrc_pkg::PERIOD_RST;
			resonant_mode <= 1'b0;
			out_a_rise_edge_time <= 12'h000;
			period_start <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			period_ticks <= next_period_ticks;
			resonant_mode <= next_resonant_mode;
			out_a_rise_edge_time <= next_out_a_rise_edge_time;
			period_start <= next_period_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output A: high from the edge tick to the end of the period
	always_comb begin
		// Resonant timing is produced elsewhere; fixed-rate output idles low
		next_primary_output_a = !next_resonant_mode &&
			({1'b0, next_out_a_rise_edge_time} <= next_tick_cnt);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			primary_output_a <= 1'b0;
		end else begin
			primary_output_a <= next_primary_output_a;
		end
	end

endmodule

// ===== pfrc_gate_model.sv
// Gate drive model: measures output A on-time of each switching period
`timescale 1ns/1ps
module pfrc_gate_model (
	// Drive side
	input wire logic clk_sys,
	input wire logic primary_output_a,
	input wire logic period_start,
	// On-time of the last full period
	output logic [12:0] on_time
);
	logic [12:0] acc;
	always_ff @(posedge clk_sys) begin
		acc <= period_start ? {12'h000, primary_output_a} : acc + primary_output_a;
		if (period_start) on_time <= acc;
	end
endmodule

// ===== pfrc_core_asserts.sv
// Checker for the PWM frequency and edge config block
`timescale 1ns/1ps
module pfrc_core_chk (
	// Clock and register port
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Timing outputs
	input wire logic [12:0] period_ticks,
	input wire logic resonant_mode,
	input wire logic [11:0] out_a_rise_edge_time,
	input wire logic period_start,
	input wire logic primary_output_a
);
	// First period after reset is skipped, its length is not pinned down
	logic [12:0] cnt;
	logic seen;
	always_ff @(posedge clk_sys) begin
		cnt <= (!rstn || period_start) ? 13'h0001 : cnt + 13'h0001;
		seen <= rstn && (seen || period_start);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_wr_back: assert property (reg_wr && reg_addr == 8'h41 ##1 reg_addr == 8'h41
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
	a_unmapped_zero: assert property (reg_addr > 8'h42 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cfg_hold: assert property (!period_start |-> $stable(period_ticks))
		else $error("period changed mid-period");
	a_edge_hold: assert property (!period_start |-> $stable(out_a_rise_edge_time))
		else $error("edge changed mid-period");
	a_start_once: assert property (period_start |=> !period_start)
		else $error("period start too long");
	a_start_space: assert property (period_start && seen |-> cnt == $past(period_ticks))
		else $error("period length wrong");
	a_out_edge: assert property (seen && !resonant_mode |-> primary_output_a ==
		((period_start ? 13'h0000 : cnt) >= out_a_rise_edge_time)) else $error("edge wrong");
	a_res_low: assert property (resonant_mode |-> !primary_output_a)
		else $error("output active in resonant mode");
	c_res: cover property ($rose(resonant_mode));
	c_full: cover property (period_start && out_a_rise_edge_time == 12'h000);
	c_sat: cover property (period_start && out_a_rise_edge_time == 12'hFFF);
endmodule
bind pfrc_core pfrc_core_chk u_pfrc_core_chk (.clk_sys, .rstn, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rdata, .period_ticks, .resonant_mode, .out_a_rise_edge_time,
	.period_start, .primary_output_a);

// ===== pfrc_core_test.sv
// Self-checking bench for the PWM frequency and edge config block
`timescale 1ns/1ps
module pfrc_core_test;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [11:0] mod_amount = 12'h000;
	logic [7:0] reg_rdata;
	logic [12:0] period_ticks;
	logic [12:0] on_time;
	logic [11:0] out_a_rise_edge_time;
	logic resonant_mode;
	logic period_start;
	logic primary_output_a;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	pfrc_core u_pfrc_core (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
		.mod_amount, .period_ticks, .resonant_mode, .out_a_rise_edge_time, .period_start,
		.primary_output_a);
	pfrc_gate_model u_pfrc_gate_model (.clk_sys, .primary_output_a, .period_start, .on_time);
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
		chk("rdata", {5'h00, exp}, {5'h00, reg_rdata});
	endtask
	// Third start: a write landing on a wrap edge may miss the first one
	task automatic starts;
		repeat (3) begin
			@(negedge clk_sys);
			while (period_start !== 1'b1) @(negedge clk_sys);
		end
		@(negedge clk_sys);
	endtask
	task automatic t_regs;
		chk("reset period", 13'h1000, period_ticks);
		rd(8'h42, 8'h00);
		wr(8'h41, 8'hA5);
		rd(8'h41, 8'hA5);
		wr(8'h42, 8'hF3);
		rd(8'h42, 8'hF3);
		wr(8'h43, 8'h55);
		rd(8'h43, 8'h00);
	endtask
	task automatic t_freq;
		logic [5:0] code[8] = '{6'h00, 6'h0F, 6'h10, 6'h1F, 6'h20, 6'h2F, 6'h30, 6'h36};
		logic [12:0] per[8] = '{13'h1000, 13'h0880, 13'h0800, 13'h0440, 13'h0400, 13'h0220,
			13'h0200, 13'h0140};
		foreach (code[i]) begin
			wr(8'h40, {2'b00, code[i]});
			starts();
			chk("period", per[i], period_ticks);
		end
		rd(8'h40, 8'h36);
	endtask
	// Period 320 here; columns: reg 0x42, modulation, edge, on-time
	task automatic t_edge;
		logic [7:0] r[5] = '{8'h70, 8'h78, 8'h7C, 8'h7C, 8'h78};
		logic [11:0] m[5] = '{12'h005, 12'h005, 12'h005, 12'hFFF, 12'hFFF};
		logic [12:0] e[5] = '{13'h017, 13'h012, 13'h01C, 13'hFFF, 13'h000};
		logic [12:0] o[5] = '{13'h129, 13'h12E, 13'h124, 13'h000, 13'h140};
		wr(8'h41, 8'h01);
		foreach (r[i]) begin
			wr(8'h42, r[i]);
			mod_amount = m[i];
			starts();
			chk("edge", e[i], {1'b0, out_a_rise_edge_time});
			chk("on time", o[i], on_time);
		end
		wr(8'h42, 8'h70);
		wr(8'h40, 8'h3F);
		starts();
		chk("resonant", 13'h0001, {12'h000, resonant_mode});
		chk("on time", 13'h0000, on_time);
	endtask
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		t_regs();
		t_freq();
		t_edge();
		finish_test();
	end
endmodule
